// ---- include/dfp_map.svh ----
/*
 * Address map, reset values, codes and link framing constants of the
 * debug flash-programming register block.
 * Assumes inclusion by bare name from the design and package files.
 */
`ifndef DFP_MAP_SVH
`define DFP_MAP_SVH

// ==========================================================
// Debug-port register addresses
`define DFP_ADDR_CTL 8'h02
`define DFP_ADDR_DAT 8'hB4

// ==========================================================
// Reset values
`define DFP_RST_ADDR 8'h00
`define DFP_RST_CTL 8'h00
`define DFP_RST_DAT 8'h00

// ==========================================================
// Unlock sequence codes, in order
`define DFP_UNLOCK_FIRST 8'h02
`define DFP_UNLOCK_SECOND 8'h01

// ==========================================================
// Flash command codes
`define DFP_CMD_BLOCK_RD 8'h06
`define DFP_CMD_BLOCK_WR 8'h07
`define DFP_CMD_PAGE_ERASE 8'h08
`define DFP_CMD_DEV_ERASE 8'h03

// ==========================================================
// Link instruction codes, sent MSB first after the start bit
`define DFP_INS_DATA_RD 2'h0
`define DFP_INS_DATA_WR 2'h1
`define DFP_INS_ADDR_RD 2'h2
`define DFP_INS_ADDR_WR 2'h3

// ==========================================================
// Link framing counts
`define DFP_INS_LAST 4'h1
`define DFP_BYTE_LAST 4'h7

`endif

// ---- include/dfp_pkg.sv ----
/*
 * Types of the debug flash-programming block: state enums, state structs
 * and the command check shared by the design files.
 * Assumes dfp_map.svh is on the include path.
 */
`include "dfp_map.svh"

package dfp_pkg;

	// ==========================================================
	// Unlock state, one-hot
	typedef enum logic [2:0] {
		DFP_LK_IDLE = 3'b001, // Nothing seen yet
		DFP_LK_SEEN2 = 3'b010, // First code seen
		DFP_LK_OPEN = 3'b100 // Programming enabled
	} dfp_lock_t;

	// ==========================================================
	// Link frame state, one-hot
	typedef enum logic [4:0] {
		DFP_LN_IDLE = 5'b00001, // Waiting for start bit
		DFP_LN_INS = 5'b00010, // Shifting instruction
		DFP_LN_WR = 5'b00100, // Shifting write byte
		DFP_LN_RDW = 5'b01000, // Fetching read byte
		DFP_LN_RD = 5'b10000 // Driving read byte
	} dfp_link_st_t;

	// ==========================================================
	// Register-side state
	typedef struct packed {
		logic [7:0] addr; // Debug-port address
		logic [7:0] ctl; // Programming control
		logic [7:0] dat; // Programming data
		dfp_lock_t lock; // Unlock progress
		logic expect_cmd; // Next data write is a command
		logic cmd_err; // Last command code was invalid
		logic cmd_stb; // Command pulse
		logic [7:0] cmd; // Command code
		logic byte_stb; // Operand pulse
		logic [7:0] byte_v; // Operand byte
		logic halted; // Core held stalled
		logic borrow; // Pins taken by debug port
	} dfp_main_t;

	// ==========================================================
	// Link-side state
	typedef struct packed {
		logic clk_s1; // Clock sync stage one
		logic clk_s2; // Clock sync stage two
		logic clk_q; // Delayed clock for edge find
		logic dat_s1; // Data sync stage one
		logic dat_s2; // Data sync stage two
		dfp_link_st_t st; // Frame state
		logic [3:0] cnt; // Bit counter
		logic [1:0] ins; // Instruction
		logic [7:0] sh; // Shift register
		logic oe; // Data pin drive enable
		logic dout; // Data pin drive value
		logic req; // Request pulse
		logic is_addr; // Request targets the address register
		logic is_wr; // Request is a write
	} dfp_link_t;

	// ==========================================================
	// True for one of the four accepted flash command codes
	function automatic logic dfp_cmd_ok(input logic [7:0] code);
		return (code == `DFP_CMD_BLOCK_RD) || (code == `DFP_CMD_BLOCK_WR) ||
			(code == `DFP_CMD_PAGE_ERASE) || (code == `DFP_CMD_DEV_ERASE);
	endfunction : dfp_cmd_ok

endpackage : dfp_pkg

// ---- include/dfp_if.sv ----
/*
 * Request channel from the link shifter to the register block.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps

interface dfp_if;
	logic req; // One-cycle request pulse
	logic is_addr; // Targets the address register
	logic is_wr; // Write when high
	logic [7:0] wdata; // Write byte
	logic [7:0] rdata; // Read byte, valid in the same cycle as req

	modport link (output req, output is_addr, output is_wr, output wdata, input rdata);
	modport regs (input req, input is_addr, input is_wr, input wdata, output rdata);
endinterface : dfp_if

// ---- hw/dfp_link.sv ----
/*
 * Two-wire link shifter: finds clock edges, shifts frames in and out of
 * the data pin and turns each frame into one request.
 * Assumes pins come from outside the clock domain; en from same clock.
 */
`timescale 1ns/1ps
`include "dfp_map.svh"

module dfp_link (
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, active high
	input wire logic en, // Pins borrowed by debug port
	input wire logic dbg_clk, // Debug clock pin
	input wire logic dbg_data, // Debug data pin level
	output logic dbg_drive, // Debug data drive value
	output logic dbg_oe, // Debug data drive enable
	dfp_if.link bus // Request channel
);

	dfp_pkg::dfp_link_t q_r; // Registered state
	dfp_pkg::dfp_link_t q_nxt; // Next state
	logic rise; // Debug clock rising edge

	// ==========================================================
	// Next-state logic
	always_comb begin
		q_nxt = q_r;
		q_nxt.clk_s1 = dbg_clk;
		q_nxt.clk_s2 = q_r.clk_s1;
		q_nxt.clk_q = q_r.clk_s2;
		q_nxt.dat_s1 = dbg_data;
		q_nxt.dat_s2 = q_r.dat_s1;
		q_nxt.req = 1'b0;
		rise = q_r.clk_s2 & ~q_r.clk_q;
		if (!en) begin
			// Release the pin at once when the core runs again
			q_nxt.st = dfp_pkg::DFP_LN_IDLE;
			q_nxt.oe = 1'b0;
		end else begin
			case (q_r.st)
				dfp_pkg::DFP_LN_IDLE: begin
					// Low data at a clock rise opens a frame
					if (rise && !q_r.dat_s2) begin
						q_nxt.st = dfp_pkg::DFP_LN_INS;
						q_nxt.cnt = 4'h0;
					end
				end
				dfp_pkg::DFP_LN_INS: begin
					if (rise) begin
						q_nxt.ins = {q_r.ins[0], q_r.dat_s2};
						q_nxt.cnt = q_r.cnt + 4'h1;
						if (q_r.cnt == `DFP_INS_LAST) begin
							q_nxt.is_addr = q_r.ins[0];
							q_nxt.is_wr = q_r.dat_s2;
							q_nxt.cnt = 4'h0;
							if (q_r.dat_s2) begin
								q_nxt.st = dfp_pkg::DFP_LN_WR;
							end else begin
								// Reads ask now and load next cycle
								q_nxt.req = 1'b1;
								q_nxt.st = dfp_pkg::DFP_LN_RDW;
							end
						end
					end
				end
				dfp_pkg::DFP_LN_WR: begin
					// Write byte arrives LSB first
					if (rise) begin
						q_nxt.sh = {q_r.dat_s2, q_r.sh[7:1]};
						q_nxt.cnt = q_r.cnt + 4'h1;
						if (q_r.cnt == `DFP_BYTE_LAST) begin
							q_nxt.req = 1'b1;
							q_nxt.st = dfp_pkg::DFP_LN_IDLE;
						end
					end
				end
				dfp_pkg::DFP_LN_RDW: begin
					q_nxt.sh = bus.rdata;
					q_nxt.dout = bus.rdata[0];
					q_nxt.oe = 1'b1;
					q_nxt.cnt = 4'h0;
					q_nxt.st = dfp_pkg::DFP_LN_RD;
				end
				dfp_pkg::DFP_LN_RD: begin
					// Each bit stands until the host's sampling rise
					if (rise) begin
						q_nxt.cnt = q_r.cnt + 4'h1;
						q_nxt.sh = {1'b0, q_r.sh[7:1]};
						q_nxt.dout = q_r.sh[1];
						if (q_r.cnt == `DFP_BYTE_LAST) begin
							q_nxt.oe = 1'b0;
							q_nxt.st = dfp_pkg::DFP_LN_IDLE;
						end
					end
				end
				default: begin
					q_nxt.st = dfp_pkg::DFP_LN_IDLE;
					q_nxt.oe = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_r <= '0;
			q_r.st <= dfp_pkg::DFP_LN_IDLE;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign bus.req = q_r.req;
	assign bus.is_addr = q_r.is_addr;
	assign bus.is_wr = q_r.is_wr;
	assign bus.wdata = q_r.sh;
	assign dbg_drive = q_r.dout;
	assign dbg_oe = q_r.oe;

	// ==========================================================
	// Checks
	a_oe_when_borrowed: assert property (@(posedge clk) disable iff (rst)
		dbg_oe |-> $past(en))
		else $error("data pin driven while not borrowed");

endmodule : dfp_link

// ---- hw/dfp_regs.sv ----
/*
 * Debug flash-programming registers: address, control with unlock
 * sequence, data with command decode, halt stall and pin borrowing.
 * Assumes flash engine and halt request run on SYS_CLK; pins do not.
 */
// Overview of operation
// - Control register at 0x02, eight bits, reset zero
// - Unlock needs 0x02 then 0x01 written
// - Programming stays enabled until system reset
// - Data register at 0xB4, eight bits, reset zero
// - Only commands 0x06 0x07 0x08 0x03 accepted
// - Halted device keeps core and peripherals stalled
// - Halted device lends clock and data pins
// - Address register selects data access target
`timescale 1ns/1ps
`include "dfp_map.svh"

module dfp_regs (
	input wire logic SYS_CLK, // System clock, 100 MHz
	input wire logic RESET, // Async system reset, active high
	input wire logic DEBUG_CLOCK_PIN, // Debug clock pin
	input wire logic DEBUG_DATA_PIN, // Debug data pin level
	output logic DEBUG_DATA_DRIVE, // Debug data drive value
	output logic DEBUG_DATA_OE, // Debug data drive enable
	input wire logic HALT_REQ, // Core halt request
	output logic CORE_STALL, // Core and peripherals stalled
	output logic PIN_BORROW, // Pins handed to the debug port
	output logic PROG_ENABLE, // Flash programming enabled
	output logic FLASH_CMD_STB, // Command pulse
	output logic [7:0] FLASH_CMD, // Command code
	output logic FLASH_BYTE_STB, // Operand byte pulse
	output logic [7:0] FLASH_BYTE, // Operand byte
	output logic CMD_ERROR, // Last command code invalid
	input wire logic FLASH_DONE, // Engine finished a command
	input wire logic FLASH_RD_VALID, // Engine read byte valid
	input wire logic [7:0] FLASH_RD_DATA // Engine read byte
);

	dfp_pkg::dfp_main_t q_r; // Registered state
	dfp_pkg::dfp_main_t q_nxt; // Next state
	logic ctl_wr; // Write to control register
	logic dat_wr; // Write to data register
	dfp_if bus (); // Link request channel

	// ==========================================================
	// Link shifter, active only while the pins are borrowed
	dfp_link u_link (
		.clk(SYS_CLK),
		.rst(RESET),
		.en(q_r.borrow),
		.dbg_clk(DEBUG_CLOCK_PIN),
		.dbg_data(DEBUG_DATA_PIN),
		.dbg_drive(DEBUG_DATA_DRIVE),
		.dbg_oe(DEBUG_DATA_OE),
		.bus(bus)
	);

	// ==========================================================
	// Read mux, selected by the address register
	always_comb begin
		if (bus.is_addr) begin
			bus.rdata = q_r.addr;
		end else if (q_r.addr == `DFP_ADDR_CTL) begin
			bus.rdata = q_r.ctl;
		end else if (q_r.addr == `DFP_ADDR_DAT) begin
			bus.rdata = q_r.dat;
		end else begin
			bus.rdata = 8'h00; // Unmapped reads as zero
		end
	end

	// ==========================================================
	// Write decode
	assign ctl_wr = bus.req && bus.is_wr && !bus.is_addr && (q_r.addr == `DFP_ADDR_CTL);
	assign dat_wr = bus.req && bus.is_wr && !bus.is_addr && (q_r.addr == `DFP_ADDR_DAT);

	// ==========================================================
	// Next-state logic
	always_comb begin
		q_nxt = q_r;
		q_nxt.cmd_stb = 1'b0;
		q_nxt.byte_stb = 1'b0;
		// Borrow lags stall so the core is quiet before pins switch
		q_nxt.halted = HALT_REQ;
		q_nxt.borrow = q_r.halted && HALT_REQ;
		// Engine events first; a host write in the same cycle wins
		if (FLASH_DONE) begin
			q_nxt.expect_cmd = 1'b1;
		end
		if (FLASH_RD_VALID) begin
			q_nxt.dat = FLASH_RD_DATA;
		end
		if (bus.req && bus.is_wr && bus.is_addr) begin
			q_nxt.addr = bus.wdata;
		end
		if (ctl_wr) begin
			q_nxt.ctl = bus.wdata;
			case (q_r.lock)
				dfp_pkg::DFP_LK_IDLE: begin
					if (bus.wdata == `DFP_UNLOCK_FIRST) begin
						q_nxt.lock = dfp_pkg::DFP_LK_SEEN2;
					end
				end
				dfp_pkg::DFP_LK_SEEN2: begin
					if (bus.wdata == `DFP_UNLOCK_SECOND) begin
						q_nxt.lock = dfp_pkg::DFP_LK_OPEN;
					end else if (bus.wdata != `DFP_UNLOCK_FIRST) begin
						q_nxt.lock = dfp_pkg::DFP_LK_IDLE;
					end
				end
				dfp_pkg::DFP_LK_OPEN: begin
					// Only a system reset leaves programming mode
					q_nxt.lock = dfp_pkg::DFP_LK_OPEN;
				end
				default: begin
					q_nxt.lock = dfp_pkg::DFP_LK_IDLE;
				end
			endcase
		end
		if (dat_wr) begin
			q_nxt.dat = bus.wdata;
			// Without unlock the byte is stored but goes nowhere
			if (q_r.lock == dfp_pkg::DFP_LK_OPEN) begin
				if (q_r.expect_cmd) begin
					if (dfp_pkg::dfp_cmd_ok(bus.wdata)) begin
						q_nxt.cmd_stb = 1'b1;
						q_nxt.cmd = bus.wdata;
						q_nxt.expect_cmd = 1'b0;
						q_nxt.cmd_err = 1'b0;
					end else begin
						q_nxt.cmd_err = 1'b1;
					end
				end else begin
					q_nxt.byte_stb = 1'b1;
					q_nxt.byte_v = bus.wdata;
				end
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			q_r <= '0;
			q_r.addr <= `DFP_RST_ADDR;
			q_r.ctl <= `DFP_RST_CTL;
			q_r.dat <= `DFP_RST_DAT;
			q_r.lock <= dfp_pkg::DFP_LK_IDLE;
			q_r.expect_cmd <= 1'b1;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ==========================================================
	// Outputs, all straight from state flops
	assign CORE_STALL = q_r.halted;
	assign PIN_BORROW = q_r.borrow;
	// Open bit of the one-hot lock code, so no gate sits behind the pin
	assign PROG_ENABLE = q_r.lock[2];
	assign FLASH_CMD_STB = q_r.cmd_stb;
	assign FLASH_CMD = q_r.cmd;
	assign FLASH_BYTE_STB = q_r.byte_stb;
	assign FLASH_BYTE = q_r.byte_v;
	assign CMD_ERROR = q_r.cmd_err;

	// ==========================================================
	// Checks
	a_ctl_write_stored: assert property (@(posedge SYS_CLK) disable iff (RESET)
		ctl_wr |=> (q_r.ctl == $past(bus.wdata)))
		else $error("control write not stored");

	a_unlock_second: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(ctl_wr && q_r.lock == dfp_pkg::DFP_LK_SEEN2 && bus.wdata == `DFP_UNLOCK_SECOND)
		|=> PROG_ENABLE)
		else $error("unlock sequence did not enable programming");

	a_prog_sticky: assert property (@(posedge SYS_CLK) disable iff (RESET)
		PROG_ENABLE |=> PROG_ENABLE [*3])
		else $error("programming mode left without reset");

	a_dat_write_stored: assert property (@(posedge SYS_CLK) disable iff (RESET)
		dat_wr |=> (q_r.dat == $past(bus.wdata)))
		else $error("data write not stored");

	a_cmd_code_valid: assert property (@(posedge SYS_CLK) disable iff (RESET)
		FLASH_CMD_STB |-> (dfp_pkg::dfp_cmd_ok(FLASH_CMD) && PROG_ENABLE))
		else $error("invalid or locked command issued");

	a_bad_cmd_flag: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(dat_wr && PROG_ENABLE && q_r.expect_cmd && !dfp_pkg::dfp_cmd_ok(bus.wdata))
		|=> (CMD_ERROR && !FLASH_CMD_STB))
		else $error("invalid command not flagged");

	a_borrow_stalled: assert property (@(posedge SYS_CLK) disable iff (RESET)
		PIN_BORROW |-> (CORE_STALL && $past(CORE_STALL)))
		else $error("pins borrowed while core running");

	a_route_other: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(bus.req && q_r.addr != `DFP_ADDR_DAT && !FLASH_RD_VALID) |=> $stable(q_r.dat))
		else $error("data register hit by other address");

	a_no_skip_unlock: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(q_r.lock == dfp_pkg::DFP_LK_IDLE) |=> !PROG_ENABLE)
		else $error("programming enabled without first code");

	a_wrong_code_resets: assert property (@(posedge SYS_CLK) disable iff (RESET)
		(ctl_wr && q_r.lock == dfp_pkg::DFP_LK_SEEN2 && bus.wdata != `DFP_UNLOCK_SECOND
		&& bus.wdata != `DFP_UNLOCK_FIRST) |=> (q_r.lock == dfp_pkg::DFP_LK_IDLE))
		else $error("wrong second code kept unlock progress");

endmodule : dfp_regs

// ---- sim/dfp_host_model.sv ----
/*
 * Host adapter model: drives the debug clock pin and shares the data pin,
 * sending start, instruction and byte frames on request.
 * Assumes the device drive enable and value come straight from the block.
 */
`timescale 1ns/1ps

module dfp_host_model (
	output logic dbg_clk, // Debug clock pin
	output logic dbg_wire, // Resolved data pin level
	input wire logic dev_oe, // Device drive enable
	input wire logic dev_val // Device drive value
);
	logic host_en; // Host drives the data pin
	logic host_val; // Last value the host drove

	// ==========================================================
	// Pin resolution
	// Released line shows the inverse of the last value, never a held copy
	assign dbg_wire = dev_oe ? dev_val : (host_en ? host_val : ~host_val);

	// Clock rests low between frames; only the host drives it
	initial begin
		dbg_clk = 1'b0;
		host_en = 1'b1;
		host_val = 1'b1;
	end

	// ==========================================================
	// One clock period, sampling at the rise
	task tick(input logic drive, input logic v, output logic seen);
		host_en = drive;
		if (drive) begin
			host_val = v;
		end
		#62.5 dbg_clk = 1'b1;
		seen = dbg_wire;
		#62.5 dbg_clk = 1'b0;
	endtask : tick

	// ==========================================================
	// Whole frame: start, instruction MSB first, byte LSB first
	task frame(input logic [1:0] ins, input logic [7:0] wb, output logic [7:0] rb);
		logic s;
		int i;
		rb = 8'h00;
		tick(1'b1, 1'b0, s);
		tick(1'b1, ins[1], s);
		tick(1'b1, ins[0], s);
		for (i = 0; i < 8; i++) begin
			if (ins[0]) begin
				tick(1'b1, wb[i], s);
			end else begin
				tick(1'b0, 1'b0, s);
				rb[i] = s;
			end
		end
		// Host keeps its level steady between frames
		host_en = 1'b1;
	endtask : frame

endmodule : dfp_host_model

// ---- sim/test_debug_flash_program_regs.sv ----
/*
 * Testbench of the debug flash-programming registers: link frames from
 * the host model, flash-side pulses from the bench, checks on all outputs.
 * Assumes dfp_map.svh is on the include path.
 */
`timescale 1ns/1ps
`include "dfp_map.svh"

module test_debug_flash_program_regs;
	logic sys_clk, rst, dbg_clk, dbg_wire, dbg_out, dbg_oe, halt_req;
	logic stall, borrow, prog_en, cmd_stb, byte_stb, cmd_err, done, rd_valid;
	logic [7:0] cmd, byte_v, rd_data, r;
	logic [7:0] codes [4] = '{`DFP_CMD_BLOCK_RD, `DFP_CMD_BLOCK_WR,
		`DFP_CMD_PAGE_ERASE, `DFP_CMD_DEV_ERASE};
	int n_errors = 0, checks_done = 0, n_cmd = 0, n_byte = 0;

	dfp_host_model host (.dbg_clk(dbg_clk), .dbg_wire(dbg_wire), .dev_oe(dbg_oe),
		.dev_val(dbg_out));
	dfp_regs dut (.SYS_CLK(sys_clk), .RESET(rst), .DEBUG_CLOCK_PIN(dbg_clk),
		.DEBUG_DATA_PIN(dbg_wire), .DEBUG_DATA_DRIVE(dbg_out), .DEBUG_DATA_OE(dbg_oe),
		.HALT_REQ(halt_req), .CORE_STALL(stall), .PIN_BORROW(borrow),
		.PROG_ENABLE(prog_en), .FLASH_CMD_STB(cmd_stb), .FLASH_CMD(cmd),
		.FLASH_BYTE_STB(byte_stb), .FLASH_BYTE(byte_v), .CMD_ERROR(cmd_err),
		.FLASH_DONE(done), .FLASH_RD_VALID(rd_valid), .FLASH_RD_DATA(rd_data));

	// ==========================================================
	// Clock and strobe counters
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (cmd_stb === 1'b1) n_cmd++;
		if (byte_stb === 1'b1) n_byte++;
	end

	// ==========================================================
	// Helpers
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : chk

	// Address frame always precedes the data frame
	task wr(input logic [7:0] a, input logic [7:0] d);
		host.frame(`DFP_INS_ADDR_WR, a, r);
		host.frame(`DFP_INS_DATA_WR, d, r);
		repeat (4) @(negedge sys_clk);
	endtask : wr

	task rd(input logic [7:0] a);
		host.frame(`DFP_INS_ADDR_WR, a, r);
		host.frame(`DFP_INS_DATA_RD, 8'h00, r);
		repeat (4) @(negedge sys_clk);
	endtask : rd

	task pulse_done;
		@(negedge sys_clk) done = 1'b1;
		@(negedge sys_clk) done = 1'b0;
	endtask : pulse_done

	task report_and_stop;
		$display("checks %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	// Bound on the whole run
	initial begin
		// Clean run needs under a quarter of this
		#400us;
		n_errors++;
		report_and_stop();
	end

	// ==========================================================
	// Main sequence
	initial begin
		// Reset held four cycles with every input at rest
		rst = 1'b1;
		halt_req = 1'b0;
		done = 1'b0;
		rd_valid = 1'b0;
		rd_data = 8'h00;
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		chk({7'h00, prog_en}, 8'h00);
		// Refused: pins not borrowed yet
		wr(`DFP_ADDR_CTL, 8'h55);
		chk({6'h00, stall, borrow}, 8'h00);
		chk({7'h00, dbg_oe}, 8'h00);
		halt_req = 1'b1;
		@(negedge sys_clk);
		chk({7'h00, stall}, 8'h01);
		repeat (3) @(negedge sys_clk);
		chk({7'h00, borrow}, 8'h01);
		rd(`DFP_ADDR_CTL);
		chk(r, 8'h00);
		rd(`DFP_ADDR_DAT);
		chk(r, 8'h00);
		host.frame(`DFP_INS_ADDR_RD, 8'h00, r);
		chk(r, `DFP_ADDR_DAT);
		// Unmapped address swallows writes and reads zero
		wr(8'h55, 8'hA5);
		rd(8'h55);
		chk(r, 8'h00);
		$display("test reset and map done");
		// Wrong orders never unlock
		wr(`DFP_ADDR_CTL, 8'h01);
		wr(`DFP_ADDR_CTL, 8'h02);
		wr(`DFP_ADDR_CTL, 8'h03);
		chk({7'h00, prog_en}, 8'h00);
		rd(`DFP_ADDR_CTL);
		chk(r, 8'h03);
		wr(`DFP_ADDR_DAT, 8'h07);
		chk(n_cmd[7:0], 8'h00);
		rd(`DFP_ADDR_DAT);
		chk(r, 8'h07);
		wr(`DFP_ADDR_CTL, 8'h02);
		wr(`DFP_ADDR_CTL, 8'h02);
		chk({7'h00, prog_en}, 8'h00);
		wr(`DFP_ADDR_CTL, 8'h01);
		chk({7'h00, prog_en}, 8'h01);
		$display("test unlock done");
		// Every accepted command with one operand
		for (int k = 0; k < 4; k++) begin
			wr(`DFP_ADDR_DAT, codes[k]);
			chk(cmd, codes[k]);
			chk(n_cmd[7:0], 8'(k + 1));
			chk({7'h00, cmd_err}, 8'h00);
			wr(`DFP_ADDR_DAT, 8'h5A + 8'(k));
			chk(byte_v, 8'h5A + 8'(k));
			chk(n_byte[7:0], 8'(k + 1));
			pulse_done();
		end
		wr(`DFP_ADDR_DAT, 8'h09);
		chk({7'h00, cmd_err}, 8'h01);
		chk(n_cmd[7:0], 8'h04);
		chk(n_byte[7:0], 8'h04);
		wr(`DFP_ADDR_DAT, `DFP_CMD_BLOCK_RD);
		chk({7'h00, cmd_err}, 8'h00);
		// Engine read byte lands in the data register
		@(negedge sys_clk);
		rd_data = 8'hC3;
		rd_valid = 1'b1;
		@(negedge sys_clk);
		rd_valid = 1'b0;
		rd(`DFP_ADDR_DAT);
		chk(r, 8'hC3);
		$display("test commands done");
		// Programming mode holds until system reset
		wr(`DFP_ADDR_CTL, 8'h00);
		chk({7'h00, prog_en}, 8'h01);
		halt_req = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk({6'h00, stall, borrow}, 8'h00);
		chk({7'h00, prog_en}, 8'h01);
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk({7'h00, prog_en}, 8'h00);
		rst = 1'b0;
		halt_req = 1'b1;
		repeat (4) @(negedge sys_clk);
		rd(`DFP_ADDR_CTL);
		chk(r, 8'h00);
		$display("test sticky mode done");
		report_and_stop();
	end

endmodule : test_debug_flash_program_regs
